/* File: include/csm_pkg.sv */
package csm_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTL0   = 8'h00;
  localparam logic [7:0] ADDR_CTL1   = 8'h04;
  localparam logic [7:0] ADDR_BT0    = 8'h08;
  localparam logic [7:0] ADDR_BT1    = 8'h0c;
  localparam logic [7:0] ADDR_RFLG   = 8'h10;
  localparam logic [7:0] ADDR_RIER   = 8'h14;
  localparam logic [7:0] ADDR_TFLG   = 8'h18;
  localparam logic [7:0] ADDR_TIER   = 8'h1c;
  localparam logic [7:0] ADDR_TARQ   = 8'h20;
  localparam logic [7:0] ADDR_TAAK   = 8'h24;
  localparam logic [7:0] ADDR_TBSEL  = 8'h28;
  localparam logic [7:0] ADDR_IDAC   = 8'h2c;
  localparam logic [7:0] ADDR_STAT   = 8'h30;
  localparam logic [7:0] ADDR_ID0    = 8'h40;
  localparam logic [7:0] ADDR_MASK0  = 8'h60;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int C0_INIT_REQUEST = 0;
  localparam int C0_SLEEP_REQUEST  = 1;
  localparam int C0_WAKEUP_ENABLE   = 2;
  localparam int C0_TIME   = 3;
  localparam int C0_SYNCH  = 4;
  localparam int C0_SWAI   = 5;
  localparam int C0_RXACT  = 6;
  localparam int C0_RECEIVED_FRAME_FLAG  = 7;
  localparam int C1_INIT_ACKNOWLEDGE = 0;
  localparam int C1_SLEEP_ACKNOWLEDGE  = 1;
  localparam int RF_WAKEUP_INTERRUPT_FLAG  = 7;
  localparam int RI_WAKEUP_INTERRUPT_ENABLE  = 7;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [7:0] CTL0_RST      = 8'h01;
  localparam logic [7:0] CTL0_KEEP     = 8'h07;
  localparam logic [7:0] CTL0_SW_WR    = 8'h2c;
  localparam logic [7:0] CTL1_RST      = 8'h10;
  localparam logic [7:0] CTL1_WR       = 8'hfc;
  localparam logic [7:0] RFLG_KEEP     = 8'h0c;
  localparam logic [7:0] RIER_KEEP     = 8'h0c;
  localparam logic [7:0] TFLG_RST      = 8'h07;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;

  typedef enum logic [1:0] {CSM_RUN, CSM_SLEEP, CSM_INIT, CSM_RESYNC} csm_mode_t;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] bt0;
    logic [7:0] bt1;
    logic [7:0] rflg;
    logic [7:0] rier;
    logic [7:0] tflg;
    logic [7:0] tier;
    logic [7:0] tarq;
    logic [7:0] taak;
    logic [7:0] tbsel;
    logic [7:0] idac;
    logic [7:0][7:0] ids;
    logic [7:0][7:0] masks;
  } csm_regs_t;

  typedef struct packed {
    csm_regs_t  r;
    csm_mode_t  mode;
    logic [3:0] rec_cnt;
    logic       bus_tx;
    logic       abort;
    logic       ack;
    logic [31:0] rdat;
  } csm_state_t;

endpackage

/* File: hdl/csm_mode_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - sleep request waits for idle bus (no rx, all tx buffers empty)
// - sleep acknowledge set once sleep is really entered
// - setting sleep request refused while wake-up flag set
// - sleep lasts until cleared or until init is requested; wake-up enable lets bus activity clear it
// - init request aborts traffic at once and drops bus sync
// - init acknowledge set once init mode is reached
// - entering init mode resets control 0, flags, enables, abort and select
// - init reset spares wake-up enable, both requests and tx status; rx status is cleared
// - control 1, timing, acceptance registers writable only in init mode
// - after init exit, resync after 11 recessive bits unless bus-off
// - clearing sleep request ignored until sleep acknowledge is 1
// - clearing init request ignored until init acknowledge is 1
// - init request forces tx pin recessive at once
// - cpu stop, or wait with stop-in-wait, forces tx recessive
// - received-frame flag set only in normal mode
// - sleep request 0 means running, 1 means pending or active sleep
// - clearing sleep request also clears sleep acknowledge
// - tx pin 0 is dominant, 1 is recessive
module csm_mode_ctrl
  import csm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        bus_rx_i,
  input  wire logic        bit_tick_i,
  input  wire logic        core_tx_i,
  input  wire logic        rx_busy_i,
  input  wire logic        tx_pending_i,
  input  wire logic        frame_ok_i,
  input  wire logic        bus_off_i,
  input  wire logic        cpu_stop_i,
  input  wire logic        cpu_wait_i,
  output logic             bus_tx_pin_o,
  output logic             abort_o
);

  csm_state_t s;
  csm_state_t next_s;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] sl);
    wr_byte = sl[0] ? d[7:0] : old;
  endfunction

  function automatic logic [7:0] slot(input logic [7:0] a, input logic [7:0] base);
    slot = a - base;
  endfunction

  logic       req;
  logic       wr;
  logic       in_init;
  logic       tx_force;
  logic [7:0] w;
  logic [7:0] off_id;
  logic [7:0] off_mk;

  always_comb
  begin
    next_s = s;
    req = cyc_i && stb_i && !s.ack;
    wr = req && we_i && sel_i[0];
    in_init = s.r.ctl0[C0_INIT_REQUEST] && s.r.ctl1[C1_INIT_ACKNOWLEDGE];
    w = dat_i[7:0];
    off_id = slot(adr_i, ADDR_ID0);
    off_mk = slot(adr_i, ADDR_MASK0);
    next_s.ack = req;
    next_s.abort = 1'b0;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr)
    begin
      case (adr_i)
        ADDR_CTL0:
        begin
          // request bits follow their own handshake
          if (w[C0_INIT_REQUEST] || s.r.ctl1[C1_INIT_ACKNOWLEDGE])
            next_s.r.ctl0[C0_INIT_REQUEST] = w[C0_INIT_REQUEST];
          if (!in_init)
          begin
            next_s.r.ctl0 = (s.r.ctl0 & ~CTL0_SW_WR) | (w & CTL0_SW_WR);
            next_s.r.ctl0[C0_INIT_REQUEST] = w[C0_INIT_REQUEST] | s.r.ctl0[C0_INIT_REQUEST];
            if (w[C0_INIT_REQUEST] || s.r.ctl1[C1_INIT_ACKNOWLEDGE])
              next_s.r.ctl0[C0_INIT_REQUEST] = w[C0_INIT_REQUEST];
            if (w[C0_RECEIVED_FRAME_FLAG])
              next_s.r.ctl0[C0_RECEIVED_FRAME_FLAG] = 1'b0;
            if (w[C0_SLEEP_REQUEST] && !s.r.rflg[RF_WAKEUP_INTERRUPT_FLAG])
              next_s.r.ctl0[C0_SLEEP_REQUEST] = 1'b1;
            else if (!w[C0_SLEEP_REQUEST] && s.r.ctl1[C1_SLEEP_ACKNOWLEDGE])
            begin
              next_s.r.ctl0[C0_SLEEP_REQUEST] = 1'b0;
              next_s.r.ctl1[C1_SLEEP_ACKNOWLEDGE] = 1'b0;
            end
          end
          if (w[C0_INIT_REQUEST] && !s.r.ctl0[C0_INIT_REQUEST])
            next_s.abort = 1'b1;
        end
        ADDR_CTL1:
          if (in_init)
            next_s.r.ctl1 = (s.r.ctl1 & ~CTL1_WR) | (w & CTL1_WR);
        ADDR_BT0:  if (in_init) next_s.r.bt0 = wr_byte(s.r.bt0, dat_i, sel_i);
        ADDR_BT1:  if (in_init) next_s.r.bt1 = wr_byte(s.r.bt1, dat_i, sel_i);
        ADDR_IDAC: if (in_init) next_s.r.idac = wr_byte(s.r.idac, dat_i, sel_i);
        ADDR_RFLG: if (!in_init) next_s.r.rflg = s.r.rflg & ~w;
        ADDR_RIER: if (!in_init) next_s.r.rier = w;
        ADDR_TFLG: if (!in_init) next_s.r.tflg = s.r.tflg & ~w;
        ADDR_TIER: if (!in_init) next_s.r.tier = w;
        ADDR_TARQ: if (!in_init) next_s.r.tarq = w;
        ADDR_TBSEL: if (!in_init) next_s.r.tbsel = w;
        default:
        begin
          if (in_init && off_id < 8'h20 && off_id[1:0] == 2'b00)
            next_s.r.ids[off_id[4:2]] = w;
          if (in_init && off_mk < 8'h20 && off_mk[1:0] == 2'b00)
            next_s.r.masks[off_mk[4:2]] = w;
        end
      endcase
    end

    // ----------------------------------------
    // read mux, unmapped reads as zero
    // ----------------------------------------
    next_s.rdat = '0;
    if (req && !we_i)
    begin
      case (adr_i)
        ADDR_CTL0:  next_s.rdat[7:0] = s.r.ctl0;
        ADDR_CTL1:  next_s.rdat[7:0] = s.r.ctl1;
        ADDR_BT0:   next_s.rdat[7:0] = s.r.bt0;
        ADDR_BT1:   next_s.rdat[7:0] = s.r.bt1;
        ADDR_RFLG:  next_s.rdat[7:0] = s.r.rflg;
        ADDR_RIER:  next_s.rdat[7:0] = s.r.rier;
        ADDR_TFLG:  next_s.rdat[7:0] = s.r.tflg;
        ADDR_TIER:  next_s.rdat[7:0] = s.r.tier;
        ADDR_TARQ:  next_s.rdat[7:0] = s.r.tarq;
        ADDR_TAAK:  next_s.rdat[7:0] = s.r.taak;
        ADDR_TBSEL: next_s.rdat[7:0] = s.r.tbsel;
        ADDR_IDAC:  next_s.rdat[7:0] = s.r.idac;
        ADDR_STAT:  next_s.rdat[1:0] = s.mode;
        default:
        begin
          if (off_id < 8'h20 && off_id[1:0] == 2'b00)
            next_s.rdat[7:0] = s.r.ids[off_id[4:2]];
          if (off_mk < 8'h20 && off_mk[1:0] == 2'b00)
            next_s.rdat[7:0] = s.r.masks[off_mk[4:2]];
        end
      endcase
    end

    next_s.r.ctl0[C0_RXACT] = rx_busy_i;

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    // acks are set one cycle after the mode register changes
    case (s.mode)
      CSM_RUN:
      begin
        if (frame_ok_i)
          next_s.r.ctl0[C0_RECEIVED_FRAME_FLAG] = 1'b1;
        if (s.r.ctl0[C0_INIT_REQUEST])
          next_s.mode = CSM_INIT;
        else if (s.r.ctl0[C0_SLEEP_REQUEST] && !rx_busy_i && !tx_pending_i)
          next_s.mode = CSM_SLEEP;
      end
      CSM_SLEEP:
      begin
        next_s.r.ctl1[C1_SLEEP_ACKNOWLEDGE] = next_s.r.ctl0[C0_SLEEP_REQUEST];
        if (s.r.ctl0[C0_INIT_REQUEST])
          next_s.mode = CSM_INIT;
        else if (!s.r.ctl0[C0_SLEEP_REQUEST])
          next_s.mode = CSM_RUN;
        else if (s.r.ctl0[C0_WAKEUP_ENABLE] && !bus_rx_i)
        begin
          // bus activity wakes us; flag stays set, a same-cycle write clear above is overridden
          next_s.r.ctl0[C0_SLEEP_REQUEST] = 1'b0;
          next_s.r.ctl1[C1_SLEEP_ACKNOWLEDGE] = 1'b0;
          next_s.r.rflg[RF_WAKEUP_INTERRUPT_FLAG] = 1'b1;
          next_s.mode = CSM_RUN;
        end
      end
      CSM_INIT:
      begin
        // hold reset values for the whole of init mode
        // request bits keep the write path's handshake, so an early clear stays refused
        next_s.r.ctl0 = next_s.r.ctl0 & CTL0_KEEP;
        next_s.r.rflg = s.r.rflg & RFLG_KEEP;
        next_s.r.rier = s.r.rier & RIER_KEEP;
        next_s.r.tflg = TFLG_RST;
        next_s.r.tier = ZERO8;
        next_s.r.tarq = ZERO8;
        next_s.r.taak = ZERO8;
        next_s.r.tbsel = ZERO8;
        next_s.r.ctl1[C1_SLEEP_ACKNOWLEDGE] = 1'b0;
        next_s.r.ctl1[C1_INIT_ACKNOWLEDGE] = 1'b1;
        if (!s.r.ctl0[C0_INIT_REQUEST])
        begin
          next_s.r.ctl1[C1_INIT_ACKNOWLEDGE] = 1'b0;
          next_s.rec_cnt = '0;
          next_s.mode = CSM_RESYNC;
        end
      end
      CSM_RESYNC:
      begin
        if (s.r.ctl0[C0_INIT_REQUEST])
          next_s.mode = CSM_INIT;
        else if (bit_tick_i && !bus_off_i)
        begin
          if (!bus_rx_i)
            next_s.rec_cnt = '0;
          else if (s.rec_cnt == RECESSIVE_RUN - 4'h1)
          begin
            next_s.r.ctl0[C0_SYNCH] = 1'b1;
            next_s.mode = CSM_RUN;
          end
          else
            next_s.rec_cnt = s.rec_cnt + 4'h1;
        end
      end
      default: next_s.mode = CSM_RUN;
    endcase

    if (s.r.ctl0[C0_INIT_REQUEST] || next_s.abort)
      next_s.r.ctl0[C0_SYNCH] = 1'b0;

    // ----------------------------------------
    // tx pin, 1 is recessive
    // ----------------------------------------
    tx_force = next_s.r.ctl0[C0_INIT_REQUEST] || s.r.ctl0[C0_INIT_REQUEST]
            || cpu_stop_i || (cpu_wait_i && s.r.ctl0[C0_SWAI])
            || s.mode != CSM_RUN;
    next_s.bus_tx = tx_force ? 1'b1 : core_tx_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.r.ctl0 <= CTL0_RST;
      s.r.ctl1 <= CTL1_RST | 8'h01;
      s.r.tflg <= TFLG_RST;
      s.mode <= CSM_INIT;
      s.bus_tx <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign dat_o = s.rdat;
  assign ack_o = s.ack;
  assign bus_tx_pin_o = s.bus_tx;
  assign abort_o = s.abort;

endmodule

`default_nettype wire

/* File: dv/csm_can_bus.sv */
`timescale 1ns/1ns
`default_nettype none
module csm_can_bus
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tx_i,
  input  wire logic dom_i,
  output logic      rx_o,
  output logic      tick_o
);
  logic [1:0] div;
  // fast bit time keeps resync short
  always_ff @(posedge clk_i)
    div <= rst_i ? 2'h0 : div + 2'h1;
  assign tick_o = (div == 2'h3);
  assign rx_o   = tx_i & ~dom_i;
endmodule
`default_nettype wire

/* File: dv/csm_mode_ctrl_props.sv */
`timescale 1ns/1ns
`default_nettype none
module csm_mode_ctrl_props
  import csm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        bus_rx_i,
  input wire logic        bit_tick_i,
  input wire logic        core_tx_i,
  input wire logic        rx_busy_i,
  input wire logic        tx_pending_i,
  input wire logic        frame_ok_i,
  input wire logic        bus_off_i,
  input wire logic        cpu_stop_i,
  input wire logic        cpu_wait_i,
  input wire logic        bus_tx_pin_o,
  input wire logic        abort_o
);
  logic       tk;
  logic       winit;
  logic       rwe;
  logic [7:0] radr;
  logic       st_rd;
  assign tk    = cyc_i & stb_i & ~ack_o;
  assign st_rd = ack_o & ~rwe & (radr == ADDR_STAT);
  always_ff @(posedge clk_i)
  begin
    winit <= ~rst_i & tk & we_i & sel_i[0] & dat_i[C0_INIT_REQUEST] & (adr_i == ADDR_CTL0);
    rwe   <= tk ? we_i : rwe;
    radr  <= tk ? adr_i : radr;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_INIT_TX: assert property (winit |-> bus_tx_pin_o)
    else $error("tx pin not recessive after init request");
  AST_ABORT_TX: assert property (abort_o |-> bus_tx_pin_o)
    else $error("abort without recessive tx");
  AST_ABORT_ONE: assert property (abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  AST_ABORT_CAUSE: assert property (abort_o |-> winit)
    else $error("abort without init request");
  AST_STOP_TX: assert property (cpu_stop_i |=> bus_tx_pin_o)
    else $error("tx not recessive in stop");
  AST_DOM_SRC: assert property (!bus_tx_pin_o |-> !$past(core_tx_i))
    else $error("dominant tx not from core");
  AST_STAT_INIT: assert property (st_rd && dat_o[1:0] == 2'd2 |-> bus_tx_pin_o)
    else $error("tx dominant in init mode");
  AST_ACK_ONE: assert property (tk |=> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle");
  cover property (abort_o);
  cover property (st_rd && dat_o[1:0] == 2'd1);
  cover property (cpu_stop_i ##1 !core_tx_i);
endmodule
`default_nettype wire

/* File: dv/test_can_sleep_init_mode_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_can_sleep_init_mode_control
  import csm_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, core_tx_i = 1, dom = 0;
  logic        rx_busy_i = 0, tx_pending_i = 0, frame_ok_i = 0, cpu_stop_i = 0;
  logic        bus_off_i = 0, cpu_wait_i = 0, tx_exp = 1;
  logic [7:0]  adr_i = 8'h00, bt;
  logic [3:0]  sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0;
  wire logic   ack_o, bus_rx_i, bit_tick_i, bus_tx_pin_o, abort_o;
  wire logic [31:0] dat_o;
  logic [7:0]  exp_q[$], msk_q[$];
  int          error_cnt = 0, tests_run = 0, cyc_cnt = 0;
  integer      seed = 32'h1ffa;
  always #10 clk_i = ~clk_i;
  csm_mode_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bus_rx_i(bus_rx_i), .bit_tick_i(bit_tick_i), .core_tx_i(core_tx_i), .rx_busy_i(rx_busy_i),
    .tx_pending_i(tx_pending_i), .frame_ok_i(frame_ok_i), .bus_off_i(bus_off_i),
    .cpu_stop_i(cpu_stop_i), .cpu_wait_i(cpu_wait_i),
    .bus_tx_pin_o(bus_tx_pin_o), .abort_o(abort_o));
  csm_can_bus bus_u (.clk_i(clk_i), .rst_i(rst_i), .tx_i(bus_tx_pin_o), .dom_i(dom),
    .rx_o(bus_rx_i), .tick_o(bit_tick_i));
  // ----
  // tasks
  // ----
  task give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(a, 1'b0, 8'h00);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ----
  // monitor and watchdog
  // ----
  always @(posedge clk_i)
    if (ack_o === 1'b1 && !we_i && exp_q.size() > 0)
    begin
      tests_run++;
      if ((dat_o[7:0] & msk_q[0]) !== (exp_q[0] & msk_q[0]))
      begin
        error_cnt++;
        $display("MISMATCH reg %h exp %h seen %h", adr_i, exp_q[0], dat_o[7:0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    idle(3);
    rst_i <= 1'b0;
    rd(ADDR_CTL0, CTL0_RST, 8'hff);
    rd(ADDR_CTL1, 8'h11, 8'hff);
    bt = 8'($random(seed));
    wb(ADDR_BT0, 1'b1, bt);
    rd(ADDR_BT0, bt, 8'hff);
    $display("test init done");
    wb(ADDR_CTL0, 1'b1, 8'h00);
    idle(60); // fifteen bit times of four clocks, more than the eleven resync needs
    rd(ADDR_CTL0, 8'h10, 8'h11);
    rd(ADDR_CTL1, 8'h00, 8'h01);
    wb(ADDR_BT0, 1'b1, ~bt);
    rd(ADDR_BT0, bt, 8'hff);
    $display("test exit done");
    rx_busy_i <= 1'b1;
    tx_pending_i <= 1'b1;
    wb(ADDR_CTL0, 1'b1, 8'h02);
    idle(4);
    rx_busy_i <= 1'b0;
    idle(4);
    rd(ADDR_CTL1, 8'h00, 8'h02);
    rd(ADDR_STAT, 8'h00, 8'h03);
    wb(ADDR_CTL0, 1'b1, 8'h00);
    rd(ADDR_CTL0, 8'h02, 8'h02);
    tx_pending_i <= 1'b0;
    idle(4);
    rd(ADDR_CTL1, 8'h02, 8'h02);
    rd(ADDR_STAT, 8'h01, 8'h03);
    frame_ok_i <= 1'b1;
    idle(1);
    frame_ok_i <= 1'b0;
    rd(ADDR_CTL0, 8'h00, 8'h80);
    wb(ADDR_CTL0, 1'b1, 8'h00);
    rd(ADDR_CTL1, 8'h00, 8'h02);
    rd(ADDR_CTL0, 8'h00, 8'h02);
    $display("test sleep done");
    wb(ADDR_CTL0, 1'b1, 8'h06);
    idle(4);
    dom <= 1'b1;
    idle(4);
    dom <= 1'b0;
    rd(ADDR_CTL0, 8'h04, 8'h06);
    rd(ADDR_RFLG, 8'h80, 8'h80);
    wb(ADDR_CTL0, 1'b1, 8'h06);
    rd(ADDR_CTL0, 8'h04, 8'h06);
    wb(ADDR_RFLG, 1'b1, 8'h80);
    $display("test wake done");
    idle(60);
    wb(ADDR_TIER, 1'b1, 8'h01);
    frame_ok_i <= 1'b1;
    idle(1);
    frame_ok_i <= 1'b0;
    rd(ADDR_CTL0, 8'h80, 8'h80);
    wb(ADDR_CTL0, 1'b1, 8'h06);
    idle(4);
    rd(ADDR_CTL1, 8'h02, 8'h02);
    wb(ADDR_CTL0, 1'b1, 8'h07);
    idle(4);
    rd(ADDR_CTL0, 8'h07, 8'hff);
    rd(ADDR_TIER, 8'h00, 8'h01);
    rd(ADDR_TFLG, TFLG_RST, 8'hff);
    rd(ADDR_STAT, 8'h02, 8'h03);
    rd(ADDR_TAAK, 8'h00, 8'hff);
    $display("test reinit done");
    bus_off_i <= 1'b1;
    wb(ADDR_CTL0, 1'b1, 8'h00);
    idle(60);
    rd(ADDR_STAT, 8'h03, 8'h03);
    bus_off_i <= 1'b0;
    idle(60);
    // sleep request survived init, so this clear also leaves sleep
    wb(ADDR_CTL0, 1'b1, 8'h20);
    idle(2);
    repeat (30)
    begin
      @(posedge clk_i);
      tests_run++;
      if (bus_tx_pin_o !== tx_exp)
      begin
        error_cnt++;
        $display("MISMATCH tx pin exp %b seen %b", tx_exp, bus_tx_pin_o);
      end
      tx_exp = core_tx_i | cpu_stop_i | cpu_wait_i;
      core_tx_i <= 1'($random(seed));
      cpu_stop_i <= 1'($random(seed));
      cpu_wait_i <= 1'($random(seed));
    end
    $display("test stop done");
    give_verdict();
  end
endmodule
bind csm_mode_ctrl csm_mode_ctrl_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .bus_rx_i(bus_rx_i), .bit_tick_i(bit_tick_i), .core_tx_i(core_tx_i),
  .rx_busy_i(rx_busy_i), .tx_pending_i(tx_pending_i), .frame_ok_i(frame_ok_i),
  .bus_off_i(bus_off_i), .cpu_stop_i(cpu_stop_i), .cpu_wait_i(cpu_wait_i),
  .bus_tx_pin_o(bus_tx_pin_o), .abort_o(abort_o));
`default_nettype wire
